// ===== sbd_bp_if.sv
// Carrier between the debug top and its breakpoint unit
`timescale 1ns/1ps
interface sbd_bp_if;
  logic bkpt_en;         // Breakpoint enable
  logic force_tag_select; // Force (1) or tag (0)
  logic permit;          // Halting permitted
  logic [15:0] match;    // Breakpoint match value
  logic [15:0] addr;     // Processor address bus
  logic access;          // Processor access this cycle
  logic fetch;           // Opcode fetch this cycle
  logic tag_end;         // Tagged opcode at queue end
  logic halted;          // Processor halted in debug mode
  logic halt_req;        // Halt request to processor
  logic tag;             // Tag for the fetched opcode
  modport ctl (output bkpt_en, force_tag_select, permit, match, addr,
               access, fetch, tag_end, halted, input halt_req, tag);
  modport bp (input bkpt_en, force_tag_select, permit, match, addr,
              access, fetch, tag_end, halted, output halt_req, tag);
endinterface : sbd_bp_if

// ===== sbd_breakpoint.sv
// Address-match hardware breakpoint, forced or tagged
`timescale 1ns/1ps
module sbd_breakpoint (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Configuration and processor side
  sbd_bp_if.bp bp
);
  logic hit;      // Address equals match value
  logic req_ff;   // Pending halt request
  logic tag_ff;   // Opcode tag

  // Comparator against the match register
  assign hit = bp.addr == bp.match;
  assign bp.halt_req = req_ff;
  assign bp.tag = tag_ff;

  // Halt request: set by forced hit or tagged opcode, held until halted or until enable or permit is cleared
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      req_ff <= 1'b0;
    end else if (!bp.bkpt_en || !bp.permit) begin
      req_ff <= 1'b0;
    end else if (bp.force_tag_select && bp.access && hit) begin
      req_ff <= 1'b1;
    end else if (!bp.force_tag_select && bp.tag_end) begin
      req_ff <= 1'b1;
    end else if (bp.halted) begin
      req_ff <= 1'b0;
    end
  end

  // Tag travels with the opcode fetched at the match address
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tag_ff <= 1'b0;
    end else begin
      tag_ff <= bp.bkpt_en && !bp.force_tag_select &&
                bp.fetch && hit;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  no_permit_a: assert property (!bp.permit |=> !req_ff)
    else $error("halt requested while not permitted");
  disabled_a: assert property (!bp.bkpt_en |=> !req_ff && !tag_ff)
    else $error("breakpoint active while disabled");
  force_hit_a: assert property (
    bp.bkpt_en && bp.permit && bp.force_tag_select && bp.access && hit
    |=> req_ff)
    else $error("forced match gave no halt request");
  tag_hit_a: assert property (
    bp.bkpt_en && !bp.force_tag_select && bp.fetch && hit |=> tag_ff)
    else $error("tagged fetch not tagged");
  tag_end_a: assert property (
    bp.bkpt_en && bp.permit && !bp.force_tag_select && bp.tag_end
    |=> req_ff)
    else $error("tagged opcode at queue end gave no halt request");
  req_hold_a: assert property (
    req_ff && !bp.halted && bp.bkpt_en && bp.permit |=> req_ff)
    else $error("halt request dropped before the halt");
endmodule : sbd_breakpoint

// ===== sbd_host_model.sv
// Debug host pod model that drives the shared debug pin
`timescale 1ns/1ps
module sbd_host_model (
  // Resolved wire level
  input wire logic pin_in,
  // Host drive level and enable
  output logic drv_out,
  output logic oe_out
);
  int tick_ns = 16; // Host's current idea of one debug tick
  // Host starts released
  initial begin
    drv_out = 1'h1;
    oe_out = 1'h0;
  end
  // Bit start: falling edge, low for n ticks, then release
  task automatic pull_low(input int n);
    oe_out = 1'h1;
    drv_out = 1'h0;
    #(n * tick_ns);
    oe_out = 1'h0;
  endtask : pull_low
  // Host byte, MSB first; a 0 stays low past the sample point
  task automatic send_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      pull_low(v[i] ? 4 : 20);
      #((v[i] ? 28 : 12) * tick_ns);
    end
  endtask : send_byte
  // Device byte, level sampled 10 ticks into each bit
  task automatic recv_byte(output logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      pull_low(6);
      #(4 * tick_ns);
      v[i] = pin_in;
      #(22 * tick_ns);
    end
  endtask : recv_byte
  // Long low at the slowest rate, speedup pulse, release
  task automatic sync(output int dly_ns, output int low_ns);
    oe_out = 1'h1;
    drv_out = 1'h0;
    #(160 * 16);
    drv_out = 1'h1;
    #4;
    oe_out = 1'h0;
    dly_ns = 0;
    low_ns = 0;
    // Bounded waits so a silent device cannot hang the host
    while (pin_in && dly_ns < 2000) begin
      #1;
      dly_ns++;
    end
    // Time the reply pulse and learn the tick from it
    while (!pin_in && low_ns < 4000) begin
      #1;
      low_ns++;
    end
    if (low_ns > 64) begin
      tick_ns = (low_ns + 64) / 128;
    end
    // Let the device end its speedup and release before any new bit
    #(16 * tick_ns);
  endtask : sync
endmodule : sbd_host_model

// ===== sbd_params.svh
// Constants for the single-wire background debug target block
// Notes on behaviour
// - Logic 0 reply: low 13 ticks, then speedup
// - Host edge synchronised, seen 0-1 tick late
// - After request: await high, wait 16 ticks
// - Sync reply: low 128, high 1, release
// - One breakpoint compares address with 16-bit value
// - Forced mode: any matching access requests halt
// - Tagged mode: tag opcode fetched at match
// - Enable bit 5, resets 0, gates everything
// - Bit 4 selects forced (1) or tagged (0)
// - Bit 7 permits halting; reset clears it
// - Bit 6 read-only, shows processor halted
// - Bit 3 selects clock, 0 alternate source
// - Register reached only by serial commands
`ifndef SBD_PARAMS_SVH
`define SBD_PARAMS_SVH
// Status/control field positions
`define SBD_BIT_PERMIT 3'h7
`define SBD_BIT_ACTIVE 3'h6
`define SBD_BIT_BKPT_EN 3'h5
`define SBD_BIT_FORCE_TAG 3'h4
`define SBD_BIT_CLKSEL 3'h3
// Reset values
`define SBD_CTL_RESET 1'h0
`define SBD_MATCH_RESET 16'h0000
// Timing in debug clock ticks
`define SBD_T_TX0_LOW 8'h0D
`define SBD_T_SAMPLE 8'h0A
`define SBD_T_SYNC_DLY 8'h10
`define SBD_T_SYNC_LOW 8'h80
`define SBD_T_SYNC_THRESH 8'h40
// Serial command codes
`define SBD_CMD_READ_STATUS 8'hE4
`define SBD_CMD_WRITE_CONTROL 8'hC4
`define SBD_CMD_WRITE_BKPT 8'hC2
// Payload lengths in bits, minus one
`define SBD_LEN_BYTE 5'h07
`define SBD_LEN_WORD 5'h0F
`endif

// ===== sbd_pkg.sv
// Types shared by the background debug target modules
package sbd_pkg;
  // Pin sequencer states, Gray coded along the usual path
  typedef enum logic [2:0] {
    SBD_IDLE = 3'h0,
    SBD_LOW = 3'h1,
    SBD_TXLOW = 3'h3,
    SBD_SPEED = 3'h2,
    SBD_SYWAIT = 3'h6,
    SBD_SYDLY = 3'h7,
    SBD_SYLOW = 3'h5,
    SBD_SYSPD = 3'h4
  } sbd_state_e;
  // Command parser phases
  typedef enum logic [1:0] {
    SBD_PH_CMD = 2'h0,
    SBD_PH_WDATA = 2'h1,
    SBD_PH_RDATA = 2'h3
  } sbd_phase_e;
endpackage : sbd_pkg

// ===== sbd_top.sv
// Single-wire background debug target: pin timing, sync, commands
`timescale 1ns/1ps
`include "sbd_params.svh"
module sbd_top (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Debug pin, open drain style
  input wire logic debug_pin_in,
  output logic debug_pin_out,
  output logic debug_pin_oe_out,
  // Alternate communication clock source
  input wire logic alt_clk_in,
  // Processor side
  input wire logic [15:0] cpu_addr_in,
  input wire logic cpu_access_in,
  input wire logic cpu_fetch_in,
  input wire logic cpu_tag_end_in,
  input wire logic cpu_halted_in,
  output logic halt_req_out,
  output logic opcode_tag_out
);
  // Synchronisers and edge detection
  logic pin_s1_ff, pin_s2_ff, pin_s3_ff;
  logic alt_s1_ff, alt_s2_ff, alt_s3_ff;
  logic pin_fall;    // Host falling edge seen
  logic tick;        // Debug clock tick
  // Pin sequencer
  sbd_pkg::sbd_state_e state_ff;
  logic [7:0] cnt_ff;    // Ticks in the current state
  logic samp_ff;         // Sampled host bit
  logic bit_done;        // One bit time finished
  logic sync_done;       // Sync reply finished
  logic drv_out_ff;      // Pin level driven
  logic drv_oe_ff;       // Pin drive enable
  // Command parser
  sbd_pkg::sbd_phase_e phase_ff;
  logic [4:0] bits_ff;   // Bits taken in this phase
  logic [4:0] need_ff;   // Payload length minus one
  logic tgt_ff;          // Payload goes to match value
  logic [15:0] rx_sh_ff; // Receive shifter
  logic [7:0] tx_sh_ff;  // Transmit shifter
  logic wr_ctl_ff;       // Control write pulse
  logic wr_bkpt_ff;      // Match write pulse
  logic [7:0] rx_cmd;    // Command byte being completed
  logic [7:0] status;    // Status/control read value
  // Status/control register fields
  logic permit_ff, bkpt_en_ff, force_tag_ff, clksel_ff;
  logic [15:0] match_ff;

  sbd_bp_if bpi();

  // Two-stage synchronisers plus a third stage for edges
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_s1_ff <= 1'b1;
      pin_s2_ff <= 1'b1;
      pin_s3_ff <= 1'b1;
      alt_s1_ff <= 1'b0;
      alt_s2_ff <= 1'b0;
      alt_s3_ff <= 1'b0;
    end else begin
      pin_s1_ff <= debug_pin_in;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      alt_s1_ff <= alt_clk_in;
      alt_s2_ff <= alt_s1_ff;
      alt_s3_ff <= alt_s2_ff;
    end
  end

  // Falling edge from the host starts a bit time
  assign pin_fall = !pin_s2_ff && pin_s3_ff;
  // Bus clock ticks every cycle, alternate source on its rising edge
  assign tick = clksel_ff ? 1'b1 : (alt_s2_ff && !alt_s3_ff);
  assign bit_done = (state_ff == sbd_pkg::SBD_LOW && pin_s2_ff) ||
                    (state_ff == sbd_pkg::SBD_SPEED && tick);
  assign sync_done = state_ff == sbd_pkg::SBD_SYSPD && tick;

  // Pin sequencer: bit times and the sync handshake
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_ff <= sbd_pkg::SBD_IDLE;
      cnt_ff <= 8'h00;
    end else begin
      case (state_ff)
        sbd_pkg::SBD_IDLE: begin
          // Reply with 0 drives low, else just time the host pulse
          if (pin_fall) begin
            cnt_ff <= 8'h00;
            if (phase_ff == sbd_pkg::SBD_PH_RDATA && !tx_sh_ff[7]) begin
              state_ff <= sbd_pkg::SBD_TXLOW;
            end else begin
              state_ff <= sbd_pkg::SBD_LOW;
            end
          end
        end
        sbd_pkg::SBD_LOW: begin
          if (pin_s2_ff) begin
            state_ff <= sbd_pkg::SBD_IDLE;
          end else if (tick) begin
            if (cnt_ff == `SBD_T_SYNC_THRESH - 8'h01) begin
              state_ff <= sbd_pkg::SBD_SYWAIT;
            end else begin
              cnt_ff <= cnt_ff + 8'h01;
            end
          end
        end
        sbd_pkg::SBD_TXLOW: begin
          if (tick) begin
            if (cnt_ff == `SBD_T_TX0_LOW - 8'h01) begin
              state_ff <= sbd_pkg::SBD_SPEED;
            end else begin
              cnt_ff <= cnt_ff + 8'h01;
            end
          end
        end
        sbd_pkg::SBD_SPEED: begin
          if (tick) begin
            state_ff <= sbd_pkg::SBD_IDLE;
          end
        end
        sbd_pkg::SBD_SYWAIT: begin
          // Wait for the host to let the pin rise
          if (pin_s2_ff) begin
            state_ff <= sbd_pkg::SBD_SYDLY;
            cnt_ff <= 8'h00;
          end
        end
        sbd_pkg::SBD_SYDLY: begin
          // Gap that lets the host speedup pulse end
          if (tick) begin
            if (cnt_ff == `SBD_T_SYNC_DLY - 8'h01) begin
              state_ff <= sbd_pkg::SBD_SYLOW;
              cnt_ff <= 8'h00;
            end else begin
              cnt_ff <= cnt_ff + 8'h01;
            end
          end
        end
        sbd_pkg::SBD_SYLOW: begin
          if (tick) begin
            if (cnt_ff == `SBD_T_SYNC_LOW - 8'h01) begin
              state_ff <= sbd_pkg::SBD_SYSPD;
            end else begin
              cnt_ff <= cnt_ff + 8'h01;
            end
          end
        end
        sbd_pkg::SBD_SYSPD: begin
          if (tick) begin
            state_ff <= sbd_pkg::SBD_IDLE;
          end
        end
        default: begin
          state_ff <= sbd_pkg::SBD_IDLE;
        end
      endcase
    end
  end

  // Host bit sample: a pulse that ended before the sample point is a 1
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      samp_ff <= 1'b1;
    end else if (state_ff == sbd_pkg::SBD_IDLE && pin_fall) begin
      samp_ff <= 1'b1;
    end else if (state_ff == sbd_pkg::SBD_LOW && tick &&
                 cnt_ff == `SBD_T_SAMPLE) begin
      samp_ff <= pin_s2_ff;
    end
  end

  // Pin drivers: low while replying, high for speedup, else released
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      drv_out_ff <= 1'b1;
      drv_oe_ff <= 1'b0;
    end else begin
      drv_out_ff <= state_ff == sbd_pkg::SBD_SPEED ||
                    state_ff == sbd_pkg::SBD_SYSPD;
      drv_oe_ff <= state_ff == sbd_pkg::SBD_TXLOW ||
                   state_ff == sbd_pkg::SBD_SPEED ||
                   state_ff == sbd_pkg::SBD_SYLOW ||
                   state_ff == sbd_pkg::SBD_SYSPD;
    end
  end

  assign debug_pin_out = drv_out_ff;
  assign debug_pin_oe_out = drv_oe_ff;

  // Status/control image; halt active is the processor's live state
  assign status = {permit_ff, cpu_halted_in, bkpt_en_ff, force_tag_ff,
                   clksel_ff, 3'h0};
  assign rx_cmd = {rx_sh_ff[6:0], samp_ff};

  // Command parser: command byte, then payload in or status out
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      phase_ff <= sbd_pkg::SBD_PH_CMD;
      bits_ff <= 5'h00;
      need_ff <= 5'h00;
      tgt_ff <= 1'b0;
      rx_sh_ff <= 16'h0000;
      tx_sh_ff <= 8'h00;
      wr_ctl_ff <= 1'b0;
      wr_bkpt_ff <= 1'b0;
    end else begin
      wr_ctl_ff <= 1'b0;
      wr_bkpt_ff <= 1'b0;
      if (sync_done) begin
        phase_ff <= sbd_pkg::SBD_PH_CMD;
        bits_ff <= 5'h00;
      end else if (bit_done) begin
        bits_ff <= bits_ff + 5'h01;
        case (phase_ff)
          sbd_pkg::SBD_PH_CMD: begin
            rx_sh_ff <= {rx_sh_ff[14:0], samp_ff};
            if (bits_ff == `SBD_LEN_BYTE) begin
              bits_ff <= 5'h00;
              // Only serial commands reach the register
              if (rx_cmd == `SBD_CMD_READ_STATUS) begin
                phase_ff <= sbd_pkg::SBD_PH_RDATA;
                tx_sh_ff <= status;
              end else if (rx_cmd == `SBD_CMD_WRITE_CONTROL) begin
                phase_ff <= sbd_pkg::SBD_PH_WDATA;
                need_ff <= `SBD_LEN_BYTE;
                tgt_ff <= 1'b0;
              end else if (rx_cmd == `SBD_CMD_WRITE_BKPT) begin
                phase_ff <= sbd_pkg::SBD_PH_WDATA;
                need_ff <= `SBD_LEN_WORD;
                tgt_ff <= 1'b1;
              end
            end
          end
          sbd_pkg::SBD_PH_WDATA: begin
            rx_sh_ff <= {rx_sh_ff[14:0], samp_ff};
            if (bits_ff == need_ff) begin
              phase_ff <= sbd_pkg::SBD_PH_CMD;
              bits_ff <= 5'h00;
              wr_ctl_ff <= !tgt_ff;
              wr_bkpt_ff <= tgt_ff;
            end
          end
          sbd_pkg::SBD_PH_RDATA: begin
            // Most significant bit first
            tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
            if (bits_ff == `SBD_LEN_BYTE) begin
              phase_ff <= sbd_pkg::SBD_PH_CMD;
              bits_ff <= 5'h00;
            end
          end
          default: begin
            phase_ff <= sbd_pkg::SBD_PH_CMD;
          end
        endcase
      end
    end
  end

  // Control fields, cleared by reset and written by serial command
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      permit_ff <= `SBD_CTL_RESET;
      bkpt_en_ff <= `SBD_CTL_RESET;
      force_tag_ff <= `SBD_CTL_RESET;
      clksel_ff <= `SBD_CTL_RESET;
      match_ff <= `SBD_MATCH_RESET;
    end else begin
      if (wr_ctl_ff) begin
        permit_ff <= rx_sh_ff[`SBD_BIT_PERMIT];
        bkpt_en_ff <= rx_sh_ff[`SBD_BIT_BKPT_EN];
        force_tag_ff <= rx_sh_ff[`SBD_BIT_FORCE_TAG];
        clksel_ff <= rx_sh_ff[`SBD_BIT_CLKSEL];
      end
      if (wr_bkpt_ff) begin
        match_ff <= rx_sh_ff;
      end
    end
  end

  // Breakpoint unit hookup
  assign bpi.bkpt_en = bkpt_en_ff;
  assign bpi.force_tag_select = force_tag_ff;
  assign bpi.permit = permit_ff;
  assign bpi.match = match_ff;
  assign bpi.addr = cpu_addr_in;
  assign bpi.access = cpu_access_in;
  assign bpi.fetch = cpu_fetch_in;
  assign bpi.tag_end = cpu_tag_end_in;
  assign bpi.halted = cpu_halted_in;
  assign halt_req_out = bpi.halt_req;
  assign opcode_tag_out = bpi.tag;

  sbd_breakpoint u_bkpt (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .bp(bpi)
  );

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  tx0_length_a: assert property (
    state_ff == sbd_pkg::SBD_TXLOW && tick && cnt_ff == 8'h0C
    |=> state_ff == sbd_pkg::SBD_SPEED ##1 drv_oe_ff && drv_out_ff)
    else $error("logic 0 reply not 13 ticks");
  tx0_drive_a: assert property (
    $past(state_ff) == sbd_pkg::SBD_TXLOW |-> drv_oe_ff && !drv_out_ff)
    else $error("logic 0 reply not driven low");
  edge_start_a: assert property (
    state_ff == sbd_pkg::SBD_IDLE && pin_fall
    |=> state_ff == sbd_pkg::SBD_LOW || state_ff == sbd_pkg::SBD_TXLOW)
    else $error("host falling edge did not start a bit");
  sync_thresh_a: assert property (
    state_ff == sbd_pkg::SBD_LOW && !pin_s2_ff && tick && cnt_ff == 8'h3F
    |=> state_ff == sbd_pkg::SBD_SYWAIT)
    else $error("long low not taken as sync");
  sync_wait_a: assert property (
    state_ff == sbd_pkg::SBD_SYWAIT && !pin_s2_ff
    |=> state_ff == sbd_pkg::SBD_SYWAIT ##1 !drv_oe_ff)
    else $error("sync reply before pin high");
  sync_gap_a: assert property (
    state_ff == sbd_pkg::SBD_SYDLY && tick && cnt_ff == 8'h0F
    |=> state_ff == sbd_pkg::SBD_SYLOW ##1 drv_oe_ff && !drv_out_ff)
    else $error("sync gap not 16 ticks");
  sync_low_a: assert property (
    state_ff == sbd_pkg::SBD_SYLOW && tick && cnt_ff == 8'h7F
    |=> state_ff == sbd_pkg::SBD_SYSPD)
    else $error("sync low not 128 ticks");
  sync_release_a: assert property (
    state_ff == sbd_pkg::SBD_SYSPD && tick
    |=> drv_oe_ff && drv_out_ff ##1 !drv_oe_ff)
    else $error("sync speedup or release wrong");
  bus_count_a: assert property (
    clksel_ff && state_ff == sbd_pkg::SBD_SYLOW && cnt_ff != 8'h7F
    |=> cnt_ff == $past(cnt_ff) + 8'h01)
    else $error("bus clock select not counting every cycle");
  alt_hold_a: assert property (
    !clksel_ff && !alt_s2_ff && state_ff == sbd_pkg::SBD_SYLOW
    |=> $stable(cnt_ff))
    else $error("count moved without an alternate clock tick");
endmodule : sbd_top

// ===== sbd_top_tb_top.sv
// Self-checking bench for the background debug target block
`timescale 1ns/1ps
`include "sbd_params.svh"
module sbd_top_tb_top;
  logic clk_in = 1'h0; // Bus clock, 4 ns
  logic alt_clk_in = 1'h0; // Alternate debug clock, 16 ns
  logic nrst_in = 1'h0; // Reset, active low
  logic [15:0] cpu_addr_in = 16'h0000; // Processor address
  logic cpu_access_in = 1'h0; // Access strobe
  logic cpu_fetch_in = 1'h0; // Opcode fetch strobe
  logic cpu_tag_end_in = 1'h0; // Tagged opcode at queue end
  logic cpu_halted_in = 1'h0; // Processor halted
  logic dev_out, dev_oe, host_drv, host_oe, halt_req, tag;
  wire pin; // Pulled up: low whenever a party pulls it low
  int err_count = 0;
  int total_checks = 0;
  int low_run = 0, last_low = 0, hi_run = 0, last_hi = 0;
  int dly, low;
  logic [7:0] st;
  assign pin = !(host_oe && !host_drv) && !(dev_oe && !dev_out);
  // Bus clock
  always #2 clk_in = ~clk_in;
  // Alternate clock, offset so its edges never meet the bus clock
  initial begin
    #1;
    forever #8 alt_clk_in = ~alt_clk_in;
  end
  sbd_top i_sbd_top (
    .clk_in(clk_in), .nrst_in(nrst_in), .debug_pin_in(pin),
    .debug_pin_out(dev_out), .debug_pin_oe_out(dev_oe),
    .alt_clk_in(alt_clk_in), .cpu_addr_in(cpu_addr_in),
    .cpu_access_in(cpu_access_in), .cpu_fetch_in(cpu_fetch_in),
    .cpu_tag_end_in(cpu_tag_end_in), .cpu_halted_in(cpu_halted_in),
    .halt_req_out(halt_req), .opcode_tag_out(tag)
  );
  sbd_host_model i_sbd_host_model (
    .pin_in(pin), .drv_out(host_drv), .oe_out(host_oe)
  );
  // Run lengths of the device's low drive and of its speedup
  always @(negedge clk_in) begin
    if (dev_oe === 1'h1 && dev_out === 1'h0) begin
      low_run++;
    end else if (low_run != 0) begin
      last_low = low_run;
      low_run = 0;
    end
    if (dev_oe === 1'h1 && dev_out === 1'h1) begin
      hi_run++;
    end else if (hi_run != 0) begin
      last_hi = hi_run;
      hi_run = 0;
    end
  end
  // Four-state compare
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Range compare for measured times and counts
  task automatic check_rng(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("mismatch at %0t ns: %0d not in %0d..%0d", $time, got, lo,
               hi);
    end
  endtask : check_rng
  // Sync handshake with the reply timed in ticks of t ns
  task automatic do_sync(input int t);
    @(negedge clk_in);
    i_sbd_host_model.sync(dly, low);
    check_rng(dly, 16 * t, 22 * t);
    check_rng(low, 127 * t, 129 * t);
    check_rng(i_sbd_host_model.tick_ns, t, t);
  endtask : do_sync
  // Status read over the pin
  task automatic rd_status(input logic [7:0] exp);
    @(negedge clk_in);
    i_sbd_host_model.send_byte(`SBD_CMD_READ_STATUS);
    i_sbd_host_model.recv_byte(st);
    check(st, exp);
  endtask : rd_status
  // Control write over the pin
  task automatic wr_ctl(input logic [7:0] v);
    @(negedge clk_in);
    i_sbd_host_model.send_byte(`SBD_CMD_WRITE_CONTROL);
    i_sbd_host_model.send_byte(v);
  endtask : wr_ctl
  // Breakpoint match write, high byte first
  task automatic wr_bkpt(input logic [15:0] v);
    @(negedge clk_in);
    i_sbd_host_model.send_byte(`SBD_CMD_WRITE_BKPT);
    i_sbd_host_model.send_byte(v[15:8]);
    i_sbd_host_model.send_byte(v[7:0]);
  endtask : wr_bkpt
  // One processor cycle {access, fetch, tag_end}, then outputs checked
  task automatic cpu_cyc(input logic [15:0] a, input logic [2:0] k,
                         input logic eh, input logic et);
    @(negedge clk_in);
    cpu_addr_in = a;
    {cpu_access_in, cpu_fetch_in, cpu_tag_end_in} = k;
    @(negedge clk_in);
    {cpu_access_in, cpu_fetch_in, cpu_tag_end_in} = 3'h0;
    check(halt_req, eh);
    check(tag, et);
  endtask : cpu_cyc
  // Verdict and end of run
  task automatic tally_and_finish;
    if (err_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  // Watchdog against a hung handshake
  initial begin
    #300000;
    err_count++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    repeat (5) @(negedge clk_in);
    check(dev_oe, 1'h0);
    check(halt_req, 1'h0);
    nrst_in = 1'h1;
    repeat (4) @(negedge clk_in);
    do_sync(16);
    rd_status(8'h00);
    cpu_cyc(16'h0000, 3'h4, 1'h0, 1'h0);
    wr_ctl(8'hFF);
    do_sync(4);
    check_rng(last_low, 128, 128);
    check_rng(last_hi, 1, 1);
    rd_status(8'hB8);
    check_rng(last_low, 13, 13);
    check_rng(last_hi, 1, 1);
    wr_bkpt(16'hA5C3);
    cpu_cyc(16'hA5C2, 3'h4, 1'h0, 1'h0);
    cpu_cyc(16'hA5C3, 3'h4, 1'h1, 1'h0);
    repeat (3) @(negedge clk_in);
    check(halt_req, 1'h1);
    cpu_halted_in = 1'h1;
    @(negedge clk_in);
    check(halt_req, 1'h0);
    rd_status(8'hF8);
    cpu_halted_in = 1'h0;
    wr_ctl(8'hA8);
    cpu_cyc(16'hA5C3, 3'h4, 1'h0, 1'h0);
    cpu_cyc(16'hA5C3, 3'h2, 1'h0, 1'h1);
    cpu_cyc(16'h0000, 3'h1, 1'h1, 1'h0);
    cpu_halted_in = 1'h1;
    @(negedge clk_in);
    cpu_halted_in = 1'h0;
    wr_ctl(8'h38);
    cpu_cyc(16'hA5C3, 3'h4, 1'h0, 1'h0);
    wr_ctl(8'h28);
    cpu_cyc(16'hA5C3, 3'h2, 1'h0, 1'h1);
    cpu_cyc(16'h0000, 3'h1, 1'h0, 1'h0);
    wr_ctl(8'h98);
    cpu_cyc(16'hA5C3, 3'h7, 1'h0, 1'h0);
    rd_status(8'h98);
    tally_and_finish();
  end
endmodule : sbd_top_tb_top
